// ==== hw/rxd_pkg.sv ====
// constants for the receive decoder crc and status block
package rxd_pkg;
  // register offsets (word index equals printed offset on the plain port)
  localparam logic [7:0] OFF_RESULT = 8'h13;
  localparam logic [7:0] OFF_CRC_CFG = 8'h12;
  localparam logic [7:0] OFF_RX_CTRL = 8'h40;
  // crc config field positions
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_INVERT_BIT = 1;
  localparam int CFG_WIDTH_BIT = 2;
  localparam int CFG_SEL_LSB = 3;
  localparam int CFG_ALIGN_LSB = 8;
  localparam int CFG_PRESET_LSB = 16;
  // rx control field positions
  localparam int CTL_MULTI_BIT = 0;
  localparam int CTL_INVPAR_BIT = 1;
  localparam int CTL_PARITY_BIT = 2;
  localparam int CTL_ODDPAR_BIT = 3;
  // result field positions
  localparam int RES_BYTES_LSB = 0;
  localparam int RES_FRAMES_LSB = 9;
  localparam int RES_LASTBITS_LSB = 13;
  localparam int RES_INTEG_BIT = 16;
  localparam int RES_FRAMING_BIT = 17;
  localparam int RES_COLL_BIT = 18;
  localparam int RES_COLLPOS_LSB = 19;
  // reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // crc seeds, residues and polynomials
  localparam logic [15:0] SEED_0 = 16'h0000;
  localparam logic [15:0] SEED_1 = 16'h6363;
  localparam logic [15:0] SEED_2 = 16'ha671;
  localparam logic [15:0] SEED_3 = 16'hffff;
  localparam logic [15:0] SEED_4 = 16'h0012;
  localparam logic [15:0] SEED_5 = 16'he012;
  localparam logic [15:0] RESIDUE_INV = 16'hf0b8;
  localparam logic [15:0] RESIDUE_PLAIN = 16'h0000;
  localparam logic [15:0] POLY16 = 16'h8408;
  localparam logic [4:0] POLY5 = 5'h14;
  // protocol detector results
  typedef enum logic [1:0] {
    RXD_PROT_A = 2'b00,
    RXD_PROT_B = 2'b01,
    RXD_PROT_JIS = 2'b10,
    RXD_PROT_15693 = 2'b11
  } rxd_prot_t;
endpackage

// ==== hw/rxd_crc.sv ====
// serial lsb-first crc engine, 16 or 5 bit
`timescale 1ns/1ps
`default_nettype none
module rxd_crc (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic seed_i,
  input wire logic [15:0] seed_val_i,
  input wire logic width5_i,
  input wire logic bit_vld_i,
  input wire logic bit_i,
  output logic [15:0] crc_o
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic fb;

  always_comb begin
    fb = crc_r[0] ^ bit_i;
    crc_nxt = crc_r;
    if (width5_i) begin
      crc_nxt = {11'h000, 1'b0, crc_r[4:1]};
      if (fb) begin
        crc_nxt[4:0] = crc_nxt[4:0] ^ rxd_pkg::POLY5;
      end
    end else begin
      crc_nxt = {1'b0, crc_r[15:1]};
      if (fb) begin
        crc_nxt = crc_nxt ^ rxd_pkg::POLY16;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      crc_r <= 16'h0000;
    end else if (seed_i) begin
      crc_r <= width5_i ? {8'h00, seed_val_i[7:0]} : seed_val_i;
    end else if (bit_vld_i) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_o = crc_r;
endmodule
`default_nettype wire

// ==== hw/rxd_top.sv ====
// receive decoder: crc check, collision and result status word
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rxd_top #(
  parameter int BYTE_CNT_W = 9,
  parameter int FRAME_CNT_W = 4
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rx_enable_i,
  input wire logic frame_start_i,
  input wire logic bit_vld_i,
  input wire logic bit_i,
  input wire logic parity_vld_i,
  input wire logic parity_i,
  input wire logic coll_i,
  input wire logic coll_mode_ok_i,
  input wire logic frame_fault_i,
  input wire logic frame_end_i,
  input wire logic detect_vld_i,
  input wire rxd_pkg::rxd_prot_t detect_prot_i,
  input wire logic detect_fast_i,
  output logic receive_done_event_o,
  output logic collision_index_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_byte_vld_o
);
  logic [31:0] cfg_r;
  logic [31:0] ctl_r;
  logic [31:0] rdata_r;
  logic [BYTE_CNT_W-1:0] byte_cnt_r;
  logic [FRAME_CNT_W-1:0] frame_cnt_r;
  logic [FRAME_CNT_W-1:0] frames_seen_r;
  logic [2:0] bit_pos_r;
  logic [2:0] last_bits_r;
  logic [6:0] data_bits_r;
  logic [6:0] first_collision_index_r;
  logic coll_flag_r;
  logic coll_seen_r;
  logic framing_r;
  logic integ_r;
  logic active_r;
  logic done_r;
  logic valid_r;
  logic [7:0] shift_r;
  logic [7:0] byte_r;
  logic byte_vld_r;
  logic par_acc_r;
  logic [15:0] seed_val;
  logic [15:0] crc_val;
  logic [15:0] residue;
  logic crc_bad;
  logic par_bad;
  logic take_bit;
  logic [2:0] align;
  logic [31:0] result;

  assign align = cfg_r[rxd_pkg::CFG_ALIGN_LSB +: 3];
  assign take_bit = active_r && bit_vld_i && !framing_r;

  always_comb begin
    case (cfg_r[rxd_pkg::CFG_SEL_LSB +: 3])
      3'h0: seed_val = rxd_pkg::SEED_0;
      3'h1: seed_val = rxd_pkg::SEED_1;
      3'h2: seed_val = rxd_pkg::SEED_2;
      3'h3: seed_val = rxd_pkg::SEED_3;
      3'h4: seed_val = rxd_pkg::SEED_4;
      3'h5: seed_val = rxd_pkg::SEED_5;
      3'h7: seed_val = cfg_r[rxd_pkg::CFG_PRESET_LSB +: 16];
      default: seed_val = rxd_pkg::SEED_0;
    endcase
  end

  rxd_crc u_crc (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .seed_i(frame_start_i),
    .seed_val_i(seed_val),
    .width5_i(cfg_r[rxd_pkg::CFG_WIDTH_BIT]),
    .bit_vld_i(take_bit),
    .bit_i(bit_i),
    .crc_o(crc_val)
  );

  assign residue = cfg_r[rxd_pkg::CFG_INVERT_BIT] ? rxd_pkg::RESIDUE_INV : rxd_pkg::RESIDUE_PLAIN;
  assign crc_bad = cfg_r[rxd_pkg::CFG_ENABLE_BIT] && (crc_val != residue);
  // inverted parity as end criterion never flags
  assign par_bad = parity_vld_i && ctl_r[rxd_pkg::CTL_PARITY_BIT]
    && !ctl_r[rxd_pkg::CTL_INVPAR_BIT]
    && ((par_acc_r ^ parity_i) != ctl_r[rxd_pkg::CTL_ODDPAR_BIT]);

  // software config and detector writes; detector wins same-cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cfg_r <= rxd_pkg::CFG_RESET;
    end else if (detect_vld_i) begin
      case (detect_prot_i)
        rxd_pkg::RXD_PROT_B: begin
          cfg_r[rxd_pkg::CFG_INVERT_BIT] <= 1'b1;
          cfg_r[rxd_pkg::CFG_ENABLE_BIT] <= 1'b1;
          cfg_r[rxd_pkg::CFG_SEL_LSB +: 3] <= 3'h3;
        end
        rxd_pkg::RXD_PROT_A: begin
          cfg_r[rxd_pkg::CFG_INVERT_BIT] <= 1'b0;
          cfg_r[rxd_pkg::CFG_SEL_LSB +: 3] <= 3'h1;
        end
        rxd_pkg::RXD_PROT_JIS: begin
          cfg_r[rxd_pkg::CFG_INVERT_BIT] <= 1'b0;
          cfg_r[rxd_pkg::CFG_SEL_LSB +: 3] <= 3'h0;
          if (detect_fast_i) begin
            cfg_r[rxd_pkg::CFG_ENABLE_BIT] <= 1'b1;
          end
        end
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end else if (wr_i && addr_i == rxd_pkg::OFF_CRC_CFG) begin
      cfg_r <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctl_r <= rxd_pkg::CTL_RESET;
    end else if (wr_i && addr_i == rxd_pkg::OFF_RX_CTRL) begin
      ctl_r <= {28'h0000000, wdata_i[3:0]};
    end
  end

  // frame activity
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      active_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= active_r && frame_end_i;
      if (frame_start_i && rx_enable_i) begin
        active_r <= 1'b1;
      end else if (frame_end_i) begin
        active_r <= 1'b0;
      end
    end
  end

  // bit assembly with first-bit alignment
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bit_pos_r <= 3'h0;
      shift_r <= 8'h00;
      byte_r <= 8'h00;
      byte_vld_r <= 1'b0;
      par_acc_r <= 1'b0;
      data_bits_r <= 7'h00;
    end else begin
      byte_vld_r <= 1'b0;
      if (frame_start_i) begin
        bit_pos_r <= align;
        shift_r <= 8'h00;
        par_acc_r <= 1'b0;
        data_bits_r <= 7'h00;
      end else if (take_bit) begin
        shift_r[bit_pos_r] <= bit_i;
        par_acc_r <= par_acc_r ^ bit_i;
        data_bits_r <= data_bits_r + 7'h01;
        bit_pos_r <= bit_pos_r + 3'h1;
        if (bit_pos_r == 3'h7) begin
          byte_r <= {bit_i, shift_r[6:0]};
          byte_vld_r <= 1'b1;
          shift_r <= 8'h00;
        end
      end else if (parity_vld_i) begin
        par_acc_r <= 1'b0;
      end
    end
  end

  // byte count and last bits
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      byte_cnt_r <= '0;
      last_bits_r <= 3'h0;
    end else if (frame_start_i && rx_enable_i) begin
      byte_cnt_r <= '0;
      last_bits_r <= 3'h0;
    end else if (take_bit && bit_pos_r == 3'h7) begin
      byte_cnt_r <= byte_cnt_r + BYTE_CNT_W'(1);
    end else if (active_r && frame_end_i && bit_pos_r != 3'h0) begin
      last_bits_r <= bit_pos_r;
      byte_cnt_r <= byte_cnt_r + BYTE_CNT_W'(1);
    end
  end

  // frame count
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      frames_seen_r <= '0;
      frame_cnt_r <= '0;
    end else begin
      if (rx_enable_i && !active_r && frame_start_i && !ctl_r[rxd_pkg::CTL_MULTI_BIT]) begin
        frames_seen_r <= '0;
      end else if (active_r && frame_end_i) begin
        frames_seen_r <= frames_seen_r + FRAME_CNT_W'(1);
      end
      if (done_r) begin
        frame_cnt_r <= frames_seen_r;
      end
    end
  end

  // collision tracking
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      coll_flag_r <= 1'b0;
      coll_seen_r <= 1'b0;
      first_collision_index_r <= 7'h00;
      valid_r <= 1'b0;
    end else if (frame_start_i && rx_enable_i) begin
      // same-cycle collision still sets the flag
      coll_flag_r <= active_r && coll_i;
      coll_seen_r <= 1'b0;
      first_collision_index_r <= 7'h00;
      valid_r <= 1'b0;
    end else if (active_r && coll_i && !coll_seen_r) begin
      coll_flag_r <= 1'b1;
      coll_seen_r <= 1'b1;
      first_collision_index_r <= data_bits_r + {4'h0, align};
      valid_r <= coll_mode_ok_i;
    end
  end

  // fault flags: set beats clear
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      framing_r <= 1'b0;
      integ_r <= 1'b0;
    end else begin
      if (active_r && frame_fault_i) begin
        framing_r <= 1'b1;
      end else if (frame_start_i && rx_enable_i) begin
        framing_r <= 1'b0;
      end
      if (active_r && (par_bad || (frame_end_i && crc_bad))) begin
        integ_r <= 1'b1;
      end else if (frame_start_i && rx_enable_i) begin
        integ_r <= 1'b0;
      end
    end
  end

  always_comb begin
    result = 32'h0000_0000;
    result[rxd_pkg::RES_BYTES_LSB +: 9] = byte_cnt_r[8:0];
    result[rxd_pkg::RES_FRAMES_LSB +: 4] = frame_cnt_r[3:0];
    result[rxd_pkg::RES_LASTBITS_LSB +: 3] = last_bits_r;
    result[rxd_pkg::RES_INTEG_BIT] = integ_r;
    result[rxd_pkg::RES_FRAMING_BIT] = framing_r;
    result[rxd_pkg::RES_COLL_BIT] = coll_flag_r;
    result[rxd_pkg::RES_COLLPOS_LSB +: 7] = first_collision_index_r;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_i) begin
      if (addr_i == rxd_pkg::OFF_RESULT) begin
        rdata_r <= result;
      end else if (addr_i == rxd_pkg::OFF_CRC_CFG) begin
        rdata_r <= cfg_r;
      end else if (addr_i == rxd_pkg::OFF_RX_CTRL) begin
        rdata_r <= ctl_r;
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_r;
  assign receive_done_event_o = done_r;
  assign collision_index_valid_o = valid_r;
  assign rx_byte_o = byte_r;
  assign rx_byte_vld_o = byte_vld_r;

  a_framing_stops: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    framing_r && !frame_start_i |=> !byte_vld_r)
    else $error("byte accepted after framing fault");
  a_coll_sets_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    active_r && coll_i && !frame_start_i |=> coll_flag_r)
    else $error("collision flag not set");
  a_coll_index: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    active_r && coll_i && !coll_seen_r && !frame_start_i
    |=> first_collision_index_r == $past(data_bits_r) + {4'h0, $past(align)})
    else $error("collision index wrong");
  a_flags_cleared: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    frame_start_i && rx_enable_i && !(active_r && (frame_fault_i || par_bad)) |=> !framing_r)
    else $error("framing flag not cleared at start");
  a_crc_fault: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    active_r && frame_end_i && crc_bad |=> integ_r)
    else $error("crc mismatch not flagged");
  a_invpar_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ctl_r[rxd_pkg::CTL_INVPAR_BIT] && !integ_r && !frame_end_i |=> !integ_r)
    else $error("parity flagged with inverted parity stop");
  a_typeb_detect: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    detect_vld_i && detect_prot_i == rxd_pkg::RXD_PROT_B
    |=> cfg_r[rxd_pkg::CFG_ENABLE_BIT] && cfg_r[rxd_pkg::CFG_INVERT_BIT])
    else $error("type b detect did not set crc bits");
  a_typea_detect: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    detect_vld_i && detect_prot_i == rxd_pkg::RXD_PROT_A |=> !cfg_r[rxd_pkg::CFG_INVERT_BIT])
    else $error("type a detect did not clear invert");
  a_frame_count: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    done_r |=> frame_cnt_r == $past(frames_seen_r))
    else $error("frame count not updated");
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(rd_i) && $past(addr_i) == rxd_pkg::OFF_RESULT |-> rdata_r[31:26] == 6'h00)
    else $error("reserved status bits nonzero");
  c_collision: cover property (@(posedge mclk_i) active_r && coll_i ##1 coll_flag_r);
  c_crc_error: cover property (@(posedge mclk_i) active_r && frame_end_i && crc_bad);
  c_framing: cover property (@(posedge mclk_i) framing_r ##[1:20] done_r);
  c_parity_fault: cover property (@(posedge mclk_i) active_r && par_bad);
endmodule
`default_nettype wire

// ==== sim/rxd_card_model.sv ====
// card side model: demodulated data bits and framing pulses
`timescale 1ns/1ps
`default_nettype none
module rxd_card_model (
  input wire logic mclk_i,
  output logic frame_start_o,
  output logic bit_vld_o,
  output logic bit_o,
  output logic parity_vld_o,
  output logic parity_o,
  output logic coll_o,
  output logic frame_fault_o,
  output logic frame_end_o
);
  initial begin
    {frame_start_o, bit_vld_o, bit_o, parity_vld_o} = '0;
    {parity_o, coll_o, frame_fault_o, frame_end_o} = '0;
  end
  // kinds: 0 frame start, 1 framing fault, else frame end
  task automatic pulse(input int k);
    @(posedge mclk_i);
    case (k)
      0: frame_start_o <= 1'b1;
      1: frame_fault_o <= 1'b1;
      default: frame_end_o <= 1'b1;
    endcase
    @(posedge mclk_i);
    {frame_start_o, frame_fault_o, frame_end_o} <= '0;
  endtask
  task automatic send_par(input logic p);
    @(posedge mclk_i);
    parity_vld_o <= 1'b1;
    parity_o <= p;
    @(posedge mclk_i);
    parity_vld_o <= 1'b0;
    parity_o <= ~p;
  endtask
  // idle data line shows the inverse of the last bit
  task automatic send_bit(input logic b, input logic c);
    @(posedge mclk_i);
    bit_vld_o <= 1'b1;
    bit_o <= b;
    coll_o <= c;
    @(posedge mclk_i);
    bit_vld_o <= 1'b0;
    bit_o <= ~b;
    coll_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_rxd_top.sv ====
// self-checking bench for the receive decoder
`timescale 1ns/1ps
`default_nettype none
module tb_rxd_top;
  localparam logic [7:0] A_CFG = rxd_pkg::OFF_CRC_CFG;
  localparam logic [7:0] A_RES = rxd_pkg::OFF_RESULT;
  localparam logic [31:0] MASK = 32'hffff_e1ff;
  typedef struct {int n; logic [31:0] d; logic [31:0] exp;} rxd_row_t;
  rxd_row_t rows [4] = '{'{8, 32'ha5, 32'h1}, '{12, 32'h5a5, 32'h8002},
    '{16, 32'h1234, 32'h2}, '{1, 32'h1, 32'h2001}};
  logic [15:0] seeds [8] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff,
    16'h0012, 16'he012, 16'h0000, 16'h1234};
  logic [7:0] row_byte [4] = '{8'ha5, 8'ha5, 8'h12, 8'h00};
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rx_enable_i = 1'b1;
  logic coll_mode_ok_i = 1'b1;
  logic detect_vld_i = 1'b0;
  logic detect_fast_i = 1'b0;
  rxd_pkg::rxd_prot_t detect_prot_i = rxd_pkg::RXD_PROT_A;
  logic fstart, bvld, bdat, pvld, pdat, coll, fault, fend;
  logic [31:0] rdata_o;
  logic done_o, cvalid_o, byte_vld_o;
  logic [7:0] byte_o;
  logic [31:0] rd_v;
  logic [15:0] c;
  logic seen_done;
  logic [7:0] last_byte = 8'h00;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 mclk_i = ~mclk_i;
  rxd_card_model card (.mclk_i(mclk_i), .frame_start_o(fstart), .bit_vld_o(bvld),
    .bit_o(bdat), .parity_vld_o(pvld), .parity_o(pdat), .coll_o(coll),
    .frame_fault_o(fault), .frame_end_o(fend));
  rxd_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_enable_i(rx_enable_i),
    .frame_start_i(fstart), .bit_vld_i(bvld), .bit_i(bdat), .parity_vld_i(pvld),
    .parity_i(pdat), .coll_i(coll), .coll_mode_ok_i(coll_mode_ok_i),
    .frame_fault_i(fault), .frame_end_i(fend), .detect_vld_i(detect_vld_i),
    .detect_prot_i(detect_prot_i), .detect_fast_i(detect_fast_i),
    .receive_done_event_o(done_o), .collision_index_valid_o(cvalid_o),
    .rx_byte_o(byte_o), .rx_byte_vld_o(byte_vld_o));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done;
    end
  end
  // last complete byte of the current frame
  always @(posedge mclk_i) begin
    if (fstart === 1'b1) begin
      last_byte <= 8'h00;
    end else if (byte_vld_o === 1'b1) begin
      last_byte <= byte_o;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    rd_v = rdata_o;
  endtask
  task automatic detect(input rxd_pkg::rxd_prot_t p, input logic f);
    @(posedge mclk_i);
    detect_vld_i <= 1'b1;
    detect_prot_i <= p;
    detect_fast_i <= f;
    @(posedge mclk_i);
    detect_vld_i <= 1'b0;
  endtask
  // ci: bit carrying a collision, fi: bit before which a framing fault comes
  task automatic frame(input int n, input logic [31:0] d, input int ci, input int fi);
    seen_done = 1'b0;
    card.pulse(0);
    for (int i = 0; i < n; i++) begin
      if (i == fi) card.pulse(1);
      card.send_bit(d[i], i == ci);
    end
    card.pulse(2);
    repeat (6) begin
      #1 if (done_o === 1'b1) seen_done = 1'b1;
      @(posedge mclk_i);
    end
    rd(A_RES);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] s, input logic [7:0] b);
    logic [15:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
    end
    return r;
  endfunction
  function automatic logic [4:0] crc5(input logic [7:0] s, input logic [7:0] b);
    logic [4:0] r;
    r = s[4:0];
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ 5'h14) : (r >> 1);
    end
    return r;
  endfunction
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(A_CFG);
    chk(rd_v, 32'h0);
    rd(A_RES);
    chk(rd_v, 32'h0);
    rd(8'h7f);
    chk(rd_v, 32'h0);
    foreach (rows[i]) begin
      frame(rows[i].n, rows[i].d, -1, -1);
      chk(rd_v & MASK, rows[i].exp);
      chk({31'h0, seen_done}, 32'h1);
      chk({24'h0, last_byte}, {24'h0, row_byte[i]});
    end
    for (int k = 0; k < 8; k++) begin
      if (k != 6) begin
        c = crc16(seeds[k], 8'h3c);
        wr(A_CFG, 32'h1234_0001 | (32'(k) << 3));
        frame(24, {8'h0, c, 8'h3c}, -1, -1);
        chk(rd_v & MASK, 32'h3);
        frame(24, {8'h0, c ^ 16'h0100, 8'h3c}, -1, -1);
        chk(rd_v & MASK, 32'h0001_0003);
      end
    end
    wr(A_CFG, 32'h0000_001b);
    c = ~crc16(16'hffff, 8'h3c);
    frame(24, {8'h0, c, 8'h3c}, -1, -1);
    chk(rd_v & MASK, 32'h3);
    frame(24, {8'h0, ~c, 8'h3c}, -1, -1);
    chk(rd_v & MASK, 32'h0001_0003);
    wr(A_CFG, 32'h0000_000d);
    c = {11'h000, crc5(8'h63, 8'h3c)};
    frame(13, {19'h0, c[4:0], 8'h3c}, -1, -1);
    chk(rd_v & MASK, 32'h0000_a002);
    frame(13, {19'h0, c[4:0] ^ 5'h01, 8'h3c}, -1, -1);
    chk(rd_v & MASK, 32'h0001_a002);
    wr(A_CFG, 32'h0000_0300);
    frame(8, 32'h5a, 5, -1);
    chk(rd_v & 32'hfffc_0000, 32'h0044_0000);
    chk({31'h0, cvalid_o}, 32'h1);
    chk({24'h0, last_byte}, 32'hd0);
    coll_mode_ok_i <= 1'b0;
    frame(8, 32'h5a, 2, -1);
    chk({31'h0, cvalid_o}, 32'h0);
    coll_mode_ok_i <= 1'b1;
    wr(A_CFG, 32'h0);
    frame(16, 32'hffff, -1, 8);
    chk(rd_v & MASK, 32'h0002_0001);
    frame(8, 32'h1, -1, -1);
    chk(rd_v & MASK, 32'h1);
    wr(A_RES, 32'hffff_ffff);
    rd(A_RES);
    chk(rd_v & MASK, 32'h1);
    detect(rxd_pkg::RXD_PROT_B, 1'b0);
    rd(A_CFG);
    chk(rd_v & 32'h3, 32'h3);
    detect(rxd_pkg::RXD_PROT_A, 1'b0);
    rd(A_CFG);
    chk(rd_v & 32'h2, 32'h0);
    wr(A_CFG, 32'h0000_0002);
    detect(rxd_pkg::RXD_PROT_JIS, 1'b1);
    rd(A_CFG);
    chk(rd_v & 32'h3, 32'h1);
    wr(A_CFG, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(rxd_pkg::OFF_RX_CTRL, (k == 2) ? 32'h6 : 32'h4);
      card.pulse(0);
      for (int i = 0; i < 8; i++) begin
        card.send_bit(i == 0, 1'b0);
      end
      card.send_par(k == 0);
      card.pulse(2);
      repeat (4) @(posedge mclk_i);
      rd(A_RES);
      chk(rd_v & MASK, (k == 1) ? 32'h0001_0001 : 32'h1);
    end
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(A_RES);
    chk(rd_v, 32'h0);
    wr(rxd_pkg::OFF_RX_CTRL, 32'h1);
    frame(8, 32'h1, -1, -1);
    frame(8, 32'h1, -1, -1);
    chk(rd_v & 32'h0000_1e00, 32'h0000_0400);
    test_done;
  end
endmodule
`default_nettype wire
